// >>> src/tcc_pkg.sv
// Operation
// - Counter, compares, capture are 16-bit, byte-accessed.
// - One shared high-byte latch per timer.
// - Low-byte write loads latch and low together.
// - Counter or capture low-byte read copies high byte into latch.
// - Counter high location accesses the latch only.
// - Compare reads return bytes directly, latch untouched.
// - Latch holds across several low-byte writes.
// - Clock select picks tick source and edge.
// - Clock select zero stops all ticks.
// - Counter readable and writable without ticks.
// - Counter write beats clear and count.
// - Tick clears, increments or decrements per mode.
// - Bottom at 0x0000, maximum at 0xFFFF.
// - Top is fixed, compare A, or capture.
// - Compare A as top is double buffered in modes 9, 11, 15; mode 4 loads it at once.
// - Compare match sets its compare flag.
// - Flags in one register, masked per bit.
// - Overflow flag set where mode defines.
// - Capture edge copies counter except in capture-top modes 8, 10, 12, 14, optional noise filter.
// - Control A and B are free byte registers.
// - Select 1 full rate, 2 to 5 prescaler taps.
// - Select 7 rising, 6 falling external edges.
package tcc_pkg;

	// ==========================================================
	// Register byte addresses.
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI = 4'h3;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
	localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
	localparam logic [3:0] ADDR_CMPB_LO = 4'h6;
	localparam logic [3:0] ADDR_CMPB_HI = 4'h7;
	localparam logic [3:0] ADDR_CAP_LO = 4'h8;
	localparam logic [3:0] ADDR_CAP_HI = 4'h9;
	localparam logic [3:0] ADDR_FLAGS = 4'ha;
	localparam logic [3:0] ADDR_MASK = 4'hb;

	// ==========================================================
	// Field positions and reset values.
	localparam int CTRLA_MODE_LSB = 0;
	localparam int CTRLB_SEL_LSB = 0;
	localparam int CTRLB_MODE_LSB = 3;
	localparam int CTRLB_EDGE_BIT = 6;
	localparam int CTRLB_NC_BIT = 7;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMPA_BIT = 1;
	localparam int FLAG_CMPB_BIT = 2;
	localparam int FLAG_CAP_BIT = 5;
	localparam logic [7:0] FLAG_USED = 8'h27;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [3:0] HIST_ONES = 4'hf;

	// ==========================================================
	// Tick source selections and prescaler taps.
	localparam logic [2:0] SEL_STOP = 3'h0;
	localparam logic [2:0] SEL_DIV1 = 3'h1;
	localparam logic [2:0] SEL_DIV8 = 3'h2;
	localparam logic [2:0] SEL_DIV64 = 3'h3;
	localparam logic [2:0] SEL_DIV256 = 3'h4;
	localparam logic [2:0] SEL_DIV1024 = 3'h5;
	localparam logic [2:0] SEL_EXT_FALL = 3'h6;
	localparam logic [2:0] SEL_EXT_RISE = 3'h7;
	localparam logic [9:0] TAP_8 = 10'h007;
	localparam logic [9:0] TAP_64 = 10'h03f;
	localparam logic [9:0] TAP_256 = 10'h0ff;
	localparam logic [9:0] TAP_1024 = 10'h3ff;

	// ==========================================================
	// Count limits and waveform modes.
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} tcc_dir_t;

	// Up/down modes: 1-3 fixed top, 8-11 capture or compare A top.
	function automatic logic tcc_is_dual(input logic [3:0] mode);
		return mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
	endfunction

	function automatic logic tcc_is_fast(input logic [3:0] mode);
		return mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
	endfunction

	function automatic logic tcc_cap_top(input logic [3:0] mode);
		return mode inside {4'h8, 4'ha, 4'hc, 4'he};
	endfunction

	function automatic logic tcc_is_pwm(input logic [3:0] mode);
		return !(mode inside {4'h0, 4'h4, 4'hc, 4'hd});
	endfunction

	function automatic logic [15:0] tcc_top(input logic [3:0] mode,
		input logic [15:0] cmpA, input logic [15:0] cap);
		logic [15:0] t;
		t = CNT_MAX;
		case (mode)
			4'h1, 4'h5: t = TOP_8BIT;
			4'h2, 4'h6: t = TOP_9BIT;
			4'h3, 4'h7: t = TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: t = cmpA;
			4'h8, 4'ha, 4'hc, 4'he: t = cap;
			default: t = CNT_MAX;
		endcase
		return t;
	endfunction

endpackage

// >>> src/tcc_core.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module tcc_core
	import tcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic extTickPin,
	input wire logic capturePin,
	input wire logic compInput,
	input wire logic capSelComparator,
	output logic irqReq,
	output logic timerTick,
	output logic topReached,
	output logic bottomReached,
	output logic matchA,
	output logic matchB
);

	// ==========================================================
	// Register state.
	logic [7:0] ctrlA_reg;
	logic [7:0] ctrlB_reg;
	logic [7:0] latch_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cmpABuf_reg;
	logic [15:0] cmpBBuf_reg;
	logic [15:0] cmpA_reg;
	logic [15:0] cmpB_reg;
	logic [15:0] cap_reg;
	logic [7:0] flags_reg;
	logic [7:0] mask_reg;
	logic [7:0] rdData_reg;
	logic [9:0] pre_reg;
	tcc_dir_t dir_reg;
	logic extSync1_reg;
	logic extSync2_reg;
	logic extPrev_reg;
	logic capSync1_reg;
	logic capSync2_reg;
	logic compSync1_reg;
	logic compSync2_reg;
	logic [3:0] capHist_reg;
	logic capFilt_reg;
	logic capPrev_reg;

	// ==========================================================
	// Bus decode.
	logic wrCtrlA, wrCtrlB, wrCntLo, wrCapLo, wrCmpALo, wrCmpBLo;
	logic wrHigh, wrFlags, wrMask, rdCntLo, rdCapLo;
	assign wrCtrlA = wrStrobe && addr == ADDR_CTRL_A;
	assign wrCtrlB = wrStrobe && addr == ADDR_CTRL_B;
	assign wrCntLo = wrStrobe && addr == ADDR_CNT_LO;
	assign wrCmpALo = wrStrobe && addr == ADDR_CMPA_LO;
	assign wrCmpBLo = wrStrobe && addr == ADDR_CMPB_LO;
	assign wrCapLo = wrStrobe && addr == ADDR_CAP_LO;
	assign wrFlags = wrStrobe && addr == ADDR_FLAGS;
	assign wrMask = wrStrobe && addr == ADDR_MASK;
	assign wrHigh = wrStrobe && addr inside {ADDR_CNT_HI, ADDR_CMPA_HI,
		ADDR_CMPB_HI, ADDR_CAP_HI};
	assign rdCntLo = rdStrobe && addr == ADDR_CNT_LO;
	assign rdCapLo = rdStrobe && addr == ADDR_CAP_LO;

	// ==========================================================
	// Mode and selection fields.
	logic [3:0] mode;
	logic [2:0] tickSel;
	logic edgeRise, ncOn, dual, fast, pwm, capTop;
	logic [15:0] loadWord, topValue;
	assign mode = {ctrlB_reg[CTRLB_MODE_LSB+:2],
		ctrlA_reg[CTRLA_MODE_LSB+:2]};
	assign tickSel = ctrlB_reg[CTRLB_SEL_LSB+:3];
	assign edgeRise = ctrlB_reg[CTRLB_EDGE_BIT];
	assign ncOn = ctrlB_reg[CTRLB_NC_BIT];
	assign dual = tcc_is_dual(mode);
	assign fast = tcc_is_fast(mode);
	assign pwm = tcc_is_pwm(mode);
	assign capTop = tcc_cap_top(mode);
	assign loadWord = {latch_reg, wrData};
	assign topValue = tcc_top(mode, cmpA_reg, cap_reg);

	// ==========================================================
	// Tick selection.
	logic extRise, extFall, tapHit;
	assign extRise = extSync2_reg && !extPrev_reg;
	assign extFall = !extSync2_reg && extPrev_reg;
	assign tapHit = (tickSel == SEL_DIV8 && (pre_reg & TAP_8) == TAP_8)
		|| (tickSel == SEL_DIV64 && (pre_reg & TAP_64) == TAP_64)
		|| (tickSel == SEL_DIV256 && (pre_reg & TAP_256) == TAP_256)
		|| (tickSel == SEL_DIV1024
		&& (pre_reg & TAP_1024) == TAP_1024);
	assign timerTick = clkEn && (tickSel == SEL_DIV1 || tapHit
		|| (tickSel == SEL_EXT_RISE && extRise)
		|| (tickSel == SEL_EXT_FALL && extFall));

	// ==========================================================
	// Counter unit.
	logic atTop, atBottom, atMax, clearCnt, dirUp;
	logic [15:0] cntNext;
	tcc_dir_t dirNext;
	assign atTop = cnt_reg == topValue;
	assign atBottom = cnt_reg == CNT_BOTTOM;
	assign atMax = cnt_reg == CNT_MAX;
	assign topReached = atTop;
	assign bottomReached = atBottom;
	assign dirUp = dir_reg == DIR_UP;
	assign clearCnt = timerTick && !dual && atTop;

	always_comb begin
		cntNext = cnt_reg;
		dirNext = dir_reg;
		if (wrCntLo) begin
			cntNext = loadWord;
		end else if (clearCnt) begin
			cntNext = CNT_BOTTOM;
		end else if (timerTick && !dual) begin
			cntNext = cnt_reg + CNT_ONE;
		end else if (timerTick && dirUp && cnt_reg >= topValue) begin
			cntNext = cnt_reg - CNT_ONE;
			dirNext = DIR_DOWN;
		end else if (timerTick && !dirUp && atBottom) begin
			cntNext = cnt_reg + CNT_ONE;
			dirNext = DIR_UP;
		end else if (timerTick) begin
			cntNext = dirUp ? cnt_reg + CNT_ONE : cnt_reg - CNT_ONE;
		end
		if (!dual) begin
			dirNext = DIR_UP;
		end
	end

	// ==========================================================
	// Compare units and their buffers.
	logic updPoint;
	logic [15:0] cmpABufNext, cmpBBufNext, cmpANext, cmpBNext;
	assign cmpABufNext = wrCmpALo ? loadWord : cmpABuf_reg;
	assign cmpBBufNext = wrCmpBLo ? loadWord : cmpBBuf_reg;
	assign updPoint = timerTick && (mode inside {4'h8, 4'h9}
		? atBottom : atTop);
	assign cmpANext = (!pwm || updPoint) ? cmpABufNext
		: cmpA_reg;
	assign cmpBNext = (!pwm || updPoint) ? cmpBBufNext : cmpB_reg;
	assign matchA = cnt_reg == cmpA_reg;
	assign matchB = cnt_reg == cmpB_reg;

	// ==========================================================
	// Capture input path.
	logic capSynced, capLevel, capEvent;
	assign capSynced = capSelComparator ? compSync2_reg : capSync2_reg;
	assign capLevel = ncOn ? capFilt_reg : capSynced;
	assign capEvent = !capTop && capLevel != capPrev_reg
		&& capLevel == edgeRise;

	// ==========================================================
	// Flags and interrupt.
	logic [7:0] flagSet, flagClr, flagsNext;
	logic ovfEvent;
	assign ovfEvent = timerTick && (dual ? atBottom && !dirUp
		: fast ? atTop : atMax);
	assign flagSet = 8'((ovfEvent ? 1 << FLAG_OVF_BIT : 0)
		| (timerTick && matchA ? 1 << FLAG_CMPA_BIT : 0)
		| (timerTick && matchB ? 1 << FLAG_CMPB_BIT : 0)
		| (capEvent ? 1 << FLAG_CAP_BIT : 0));
	assign flagClr = wrFlags ? wrData & FLAG_USED : BYTE_RESET;
	assign flagsNext = (flags_reg & ~flagClr) | flagSet;
	assign irqReq = |(flags_reg & mask_reg);

	// ==========================================================
	// Read mux and latch.
	logic [7:0] rdMux, latchNext;
	always_comb begin
		rdMux = BYTE_RESET;
		unique case (addr)
			ADDR_CTRL_A: rdMux = ctrlA_reg;
			ADDR_CTRL_B: rdMux = ctrlB_reg;
			ADDR_CNT_LO: rdMux = cnt_reg[7:0];
			ADDR_CNT_HI: rdMux = latch_reg;
			ADDR_CMPA_LO: rdMux = cmpABuf_reg[7:0];
			ADDR_CMPA_HI: rdMux = cmpABuf_reg[15:8];
			ADDR_CMPB_LO: rdMux = cmpBBuf_reg[7:0];
			ADDR_CMPB_HI: rdMux = cmpBBuf_reg[15:8];
			ADDR_CAP_LO: rdMux = cap_reg[7:0];
			ADDR_CAP_HI: rdMux = latch_reg;
			ADDR_FLAGS: rdMux = flags_reg;
			ADDR_MASK: rdMux = mask_reg;
			default: rdMux = BYTE_RESET;
		endcase
	end
	assign latchNext = wrHigh ? wrData
		: rdCntLo ? cnt_reg[15:8]
		: rdCapLo ? cap_reg[15:8] : latch_reg;
	assign rdData = rdData_reg;

	// ==========================================================
	// Clocked state.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrlA_reg <= BYTE_RESET;
			ctrlB_reg <= BYTE_RESET;
			mask_reg <= BYTE_RESET;
			flags_reg <= BYTE_RESET;
			latch_reg <= BYTE_RESET;
			rdData_reg <= BYTE_RESET;
			pre_reg <= '0;
		end else if (clkEn) begin
			ctrlA_reg <= wrCtrlA ? wrData : ctrlA_reg;
			ctrlB_reg <= wrCtrlB ? wrData : ctrlB_reg;
			mask_reg <= wrMask ? wrData & FLAG_USED : mask_reg;
			flags_reg <= flagsNext;
			latch_reg <= latchNext;
			rdData_reg <= rdStrobe ? rdMux : BYTE_RESET;
			pre_reg <= pre_reg + 10'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_reg <= WORD_RESET;
			dir_reg <= DIR_UP;
			cmpABuf_reg <= WORD_RESET;
			cmpBBuf_reg <= WORD_RESET;
			cmpA_reg <= WORD_RESET;
			cmpB_reg <= WORD_RESET;
			cap_reg <= WORD_RESET;
		end else if (clkEn) begin
			cnt_reg <= cntNext;
			dir_reg <= dirNext;
			cmpABuf_reg <= cmpABufNext;
			cmpBBuf_reg <= cmpBBufNext;
			cmpA_reg <= cmpANext;
			cmpB_reg <= cmpBNext;
			if (capEvent) begin
				cap_reg <= cnt_reg;
			end else if (wrCapLo && capTop) begin
				cap_reg <= loadWord;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			extSync1_reg <= 1'b0;
			extSync2_reg <= 1'b0;
			extPrev_reg <= 1'b0;
			capSync1_reg <= 1'b0;
			capSync2_reg <= 1'b0;
			compSync1_reg <= 1'b0;
			compSync2_reg <= 1'b0;
			capHist_reg <= 4'h0;
			capFilt_reg <= 1'b0;
			capPrev_reg <= 1'b0;
		end else if (clkEn) begin
			extSync1_reg <= extTickPin;
			extSync2_reg <= extSync1_reg;
			extPrev_reg <= extSync2_reg;
			capSync1_reg <= capturePin;
			capSync2_reg <= capSync1_reg;
			compSync1_reg <= compInput;
			compSync2_reg <= compSync1_reg;
			capHist_reg <= {capHist_reg[2:0], capSynced};
			if (capHist_reg == HIST_ONES) begin
				capFilt_reg <= 1'b1;
			end else if (capHist_reg == 4'h0) begin
				capFilt_reg <= 1'b0;
			end
			capPrev_reg <= capLevel;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	sequence s_high_write;
		clkEn && wrStrobe && addr == ADDR_CNT_HI;
	endsequence

	sequence s_low_write;
		clkEn && wrCntLo;
	endsequence

	a_pair_write_loads: assert property (
		s_high_write ##1 s_low_write |=> cnt_reg[15:8] == $past(wrData, 2))
		else $error("Two-byte counter write did not load.");

	a_low_write_wins: assert property (
		clkEn && wrCntLo |=> cnt_reg == {$past(latch_reg), $past(wrData)})
		else $error("Counter write lost to counting.");

	a_low_read_latch: assert property (
		clkEn && rdCntLo |=> latch_reg == $past(cnt_reg[15:8]))
		else $error("Low read did not fill the latch.");

	a_high_read_latch: assert property (
		clkEn && rdStrobe && addr == ADDR_CNT_HI
		|=> rdData == $past(latch_reg))
		else $error("Counter high read bypassed the latch.");

	a_compare_read_direct: assert property (
		clkEn && rdStrobe && addr == ADDR_CMPA_HI
		|=> rdData == $past(cmpABuf_reg[15:8])
		&& latch_reg == $past(latch_reg))
		else $error("Compare read disturbed the latch.");

	a_latch_holds: assert property (
		clkEn && wrCmpALo |=> latch_reg == $past(latch_reg))
		else $error("Low write altered the latch.");

	a_stop_freezes: assert property (
		clkEn && tickSel == SEL_STOP && !wrCntLo
		|=> cnt_reg == $past(cnt_reg))
		else $error("Stopped counter moved.");

	a_full_rate_step: assert property (
		clkEn && tickSel == SEL_DIV1 && mode == 4'h0 && !wrCntLo
		|=> cnt_reg == $past(cnt_reg) + CNT_ONE)
		else $error("Full-rate tick did not count.");

	a_ext_rise_tick: assert property (
		clkEn && tickSel == SEL_EXT_RISE && extSync2_reg && !extPrev_reg
		|-> timerTick)
		else $error("External rising edge gave no tick.");

	a_overflow_flag: assert property (
		timerTick && mode == 4'h0 && atMax
		|=> flags_reg[FLAG_OVF_BIT])
		else $error("Overflow flag not set at maximum.");

	a_match_irq: assert property (
		timerTick && matchA && mask_reg[FLAG_CMPA_BIT] && !wrMask
		|=> irqReq && flags_reg[FLAG_CMPA_BIT])
		else $error("Compare match gave no request.");

	a_read_data_idle: assert property (
		clkEn && !rdStrobe |=> rdData == BYTE_RESET)
		else $error("Read data stood outside its cycle.");

	a_ext_fall_tick: assert property (
		clkEn && tickSel == SEL_EXT_FALL && extFall |-> timerTick)
		else $error("External falling edge gave no tick.");

	a_capture_copy: assert property (
		clkEn && capEvent
		|=> cap_reg == $past(cnt_reg) && flags_reg[FLAG_CAP_BIT])
		else $error("Capture event did not copy the counter.");

	a_capture_write_gate: assert property (
		clkEn && wrCapLo && !capTop && !capEvent
		|=> cap_reg == $past(cap_reg))
		else $error("Capture register written outside its modes.");

	a_dual_turn_down: assert property (
		timerTick && dual && dirUp && atTop && !wrCntLo
		|=> cnt_reg == $past(cnt_reg) - CNT_ONE && dir_reg == DIR_DOWN)
		else $error("Up/down counter did not turn at top.");

	a_dual_overflow: assert property (
		timerTick && dual && atBottom && !dirUp
		|=> flags_reg[FLAG_OVF_BIT])
		else $error("Up/down overflow not set at bottom.");

	a_match_a_flag: assert property (
		timerTick && matchA |=> flags_reg[FLAG_CMPA_BIT])
		else $error("Compare A match did not set its flag.");

	a_flag_clear: assert property (
		clkEn && wrFlags && wrData[FLAG_OVF_BIT] && !ovfEvent
		|=> !flags_reg[FLAG_OVF_BIT])
		else $error("Writing one did not clear the flag.");

endmodule

// >>> verif/tcc_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Processor side of the byte bus: one access per byte call, two per word call.
module tcc_cpu_model
	import tcc_pkg::*;
(
	input wire logic core_clk,
	output logic [ADDR_W-1:0] addr,
	output logic [7:0] wrData,
	output logic wrStrobe,
	output logic rdStrobe,
	input wire logic [7:0] rdData
);
	initial begin
		addr = 4'h0;
		wrData = 8'h00;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge core_clk);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge core_clk);
		rdStrobe <= 1'b0;
		@(negedge core_clk);
		d = rdData;
	endtask

	// Word accesses run back to back with nothing between.
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		@(posedge core_clk);
		addr <= lo + 4'h1;
		wrData <= v[15:8];
		wrStrobe <= 1'b1;
		@(posedge core_clk);
		addr <= lo;
		wrData <= v[7:0];
		@(posedge core_clk);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		logic [7:0] l;
		logic [7:0] h;
		@(posedge core_clk);
		addr <= lo;
		rdStrobe <= 1'b1;
		@(posedge core_clk);
		addr <= lo + 4'h1;
		@(negedge core_clk);
		l = rdData;
		@(posedge core_clk);
		rdStrobe <= 1'b0;
		@(negedge core_clk);
		h = rdData;
		v = {h, l};
	endtask
endmodule

// >>> verif/test_timer16_counter_core.sv
`timescale 1ns/1ps
module test_timer16_counter_core
	import tcc_pkg::*;
;
	logic core_clk, reset, clkEn, wrStrobe, rdStrobe, extTickPin;
	logic capturePin, compInput, capSelComparator, irqReq, timerTick;
	logic topReached, bottomReached, matchA, matchB;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wrData, rdData, b;
	logic [15:0] w;
	int mismatches, tests_run, c;

	tcc_cpu_model cpu (.core_clk(core_clk), .addr(addr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
	tcc_core dut (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
		.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .extTickPin(extTickPin),
		.capturePin(capturePin), .compInput(compInput),
		.capSelComparator(capSelComparator), .irqReq(irqReq),
		.timerTick(timerTick), .topReached(topReached),
		.bottomReached(bottomReached), .matchA(matchA), .matchB(matchB));

	always #5 core_clk = ~core_clk;

	// ==========================================================
	// Shared helpers.
	task automatic chk(input string nm, input logic [15:0] ex,
		input logic [15:0] got);
		tests_run++;
		if (got !== ex) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge core_clk);
			if (timerTick === 1'b1) c++;
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		chk("bottom", 16'h1, {15'h0, bottomReached});
		cpu.rd16(ADDR_CNT_LO, w);
		chk("cnt_reset", 16'h0, w);
		cpu.rd(ADDR_FLAGS, b);
		chk("flags_reset", 16'h0, {8'h0, b});
		cpu.wr(ADDR_CTRL_A, 8'h02);
		cpu.rd(ADDR_CTRL_A, b);
		chk("ctrl_a", 16'h02, {8'h0, b});
		cpu.wr(ADDR_CTRL_A, 8'h00);
	endtask

	task automatic t_word();
		cpu.wr16(ADDR_CNT_LO, 16'h01ff);
		repeat (5) @(posedge core_clk);
		cpu.rd16(ADDR_CNT_LO, w);
		chk("cnt_stopped", 16'h01ff, w);
		cpu.wr16(ADDR_CNT_LO, 16'h5566);
		cpu.wr16(ADDR_CMPA_LO, 16'h1234);
		cpu.rd(ADDR_CNT_LO, b);
		cpu.rd(ADDR_CMPA_HI, b);
		chk("cmpa_hi", 16'h12, {8'h0, b});
		cpu.rd(ADDR_CNT_HI, b);
		chk("latch_kept", 16'h55, {8'h0, b});
		cpu.wr(ADDR_CMPA_HI, 8'h9a);
		cpu.wr(ADDR_CMPA_LO, 8'h01);
		cpu.wr(ADDR_CMPB_LO, 8'h02);
		cpu.rd16(ADDR_CMPB_LO, w);
		chk("latch_reuse", 16'h9a02, w);
	endtask

	task automatic t_top();
		logic [7:0] ma[6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00};
		logic [7:0] mb[6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h18, 8'h00};
		logic [15:0] tp[6] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0abc,
			16'h0777, 16'hffff};
		cpu.wr16(ADDR_CMPA_LO, 16'h0abc);
		cpu.wr(ADDR_CTRL_B, 8'h18);
		cpu.wr16(ADDR_CAP_LO, 16'h0777);
		for (int i = 0; i < 6; i++) begin
			cpu.wr(ADDR_CTRL_A, ma[i]);
			cpu.wr(ADDR_CTRL_B, mb[i]);
			cpu.wr16(ADDR_CNT_LO, tp[i]);
			@(negedge core_clk);
			chk("top_at", 16'h1, {15'h0, topReached});
			cpu.wr16(ADDR_CNT_LO, tp[i] - 16'h1);
			@(negedge core_clk);
			chk("top_below", 16'h0, {15'h0, topReached});
		end
	endtask

	task automatic t_sel();
		int win[6] = '{64, 16, 64, 128, 512, 2048};
		int ex[6] = '{0, 16, 8, 2, 2, 2};
		for (int i = 0; i < 6; i++) begin
			cpu.wr(ADDR_CTRL_B, i[7:0]);
			c = 0;
			ticks(win[i]);
			chk("tick_count", ex[i][15:0], c[15:0]);
		end
		for (int s = 7; s >= 6; s--) begin
			cpu.wr(ADDR_CTRL_B, s[7:0]);
			c = 0;
			repeat (3) begin
				@(posedge core_clk);
				extTickPin <= 1'b1;
				ticks(6);
				@(posedge core_clk);
				extTickPin <= 1'b0;
				ticks(6);
			end
			chk("ext_ticks", 16'h3, c[15:0]);
		end
		cpu.wr(ADDR_CTRL_B, 8'h00);
	endtask

	task automatic t_count();
		cpu.wr(ADDR_CTRL_B, 8'h01);
		cpu.wr16(ADDR_CNT_LO, 16'h4000);
		cpu.rd16(ADDR_CNT_LO, w);
		chk("write_wins", 16'h1,
			{15'h0, w >= 16'h4000 && w < 16'h4008});
		cpu.wr(ADDR_CTRL_B, 8'h00);
		cpu.wr16(ADDR_CNT_LO, 16'hfffd);
		cpu.wr(ADDR_FLAGS, 8'hff);
		cpu.wr(ADDR_CTRL_B, 8'h01);
		repeat (4) @(posedge core_clk);
		cpu.wr(ADDR_CTRL_B, 8'h00);
		cpu.rd(ADDR_FLAGS, b);
		chk("ovf_flag", 16'h1, {15'h0, b[0]});
		chk("irq_masked", 16'h0, {15'h0, irqReq});
		cpu.wr(ADDR_MASK, 8'h01);
		@(negedge core_clk);
		chk("irq_on", 16'h1, {15'h0, irqReq});
		cpu.wr(ADDR_FLAGS, 8'h01);
		@(negedge core_clk);
		chk("irq_cleared", 16'h0, {15'h0, irqReq});
		cpu.wr(ADDR_MASK, 8'h00);
		cpu.wr16(ADDR_CNT_LO, 16'h0000);
		cpu.wr16(ADDR_CMPA_LO, 16'h0010);
		cpu.wr16(ADDR_CMPB_LO, 16'h0040);
		cpu.wr16(ADDR_CNT_LO, 16'h0040);
		@(negedge core_clk);
		chk("match_a", 16'h0, {15'h0, matchA});
		chk("match_b", 16'h1, {15'h0, matchB});
		cpu.wr16(ADDR_CNT_LO, 16'h0000);
		cpu.wr(ADDR_FLAGS, 8'hff);
		cpu.wr(ADDR_CTRL_B, 8'h01);
		repeat (24) @(posedge core_clk);
		cpu.wr(ADDR_CTRL_B, 8'h00);
		cpu.rd(ADDR_FLAGS, b);
		chk("cmp_flags", 16'h02, {8'h0, b & 8'h07});
	endtask

	task automatic t_updown();
		cpu.wr(ADDR_CTRL_A, 8'h01);
		cpu.wr16(ADDR_CNT_LO, 16'h00fd);
		cpu.wr(ADDR_CTRL_B, 8'h01);
		repeat (2) @(posedge core_clk);
		cpu.wr(ADDR_CTRL_B, 8'h00);
		cpu.rd16(ADDR_CNT_LO, w);
		chk("turned_down", 16'h00fd, w);
		cpu.wr16(ADDR_CNT_LO, 16'h0002);
		cpu.wr(ADDR_FLAGS, 8'hff);
		cpu.wr(ADDR_CTRL_B, 8'h01);
		@(posedge core_clk);
		cpu.wr(ADDR_CTRL_B, 8'h00);
		cpu.rd16(ADDR_CNT_LO, w);
		chk("turned_up", 16'h0001, w);
		cpu.rd(ADDR_FLAGS, b);
		chk("dual_ovf", 16'h1, {15'h0, b[0]});
		cpu.wr(ADDR_CTRL_A, 8'h00);
	endtask

	task automatic t_cap();
		cpu.wr16(ADDR_CNT_LO, 16'h0321);
		cpu.wr(ADDR_CTRL_B, 8'h40);
		cpu.wr(ADDR_FLAGS, 8'hff);
		@(posedge core_clk);
		capturePin <= 1'b1;
		repeat (10) @(posedge core_clk);
		cpu.rd16(ADDR_CAP_LO, w);
		chk("capture", 16'h0321, w);
		cpu.rd(ADDR_FLAGS, b);
		chk("cap_flag", 16'h1, {15'h0, b[5]});
		cpu.wr16(ADDR_CAP_LO, 16'h1111);
		cpu.rd16(ADDR_CAP_LO, w);
		chk("cap_locked", 16'h0321, w);
		cpu.wr16(ADDR_CNT_LO, 16'h0456);
		cpu.wr(ADDR_CTRL_B, 8'hc0);
		@(posedge core_clk);
		capSelComparator <= 1'b1;
		repeat (10) @(posedge core_clk);
		cpu.wr(ADDR_FLAGS, 8'hff);
		@(posedge core_clk);
		compInput <= 1'b1;
		repeat (12) @(posedge core_clk);
		cpu.rd16(ADDR_CAP_LO, w);
		chk("filtered_capture", 16'h0456, w);
		cpu.rd(ADDR_FLAGS, b);
		chk("filtered_flag", 16'h1, {15'h0, b[5]});
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		close_out();
	end

	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		clkEn = 1'b1;
		extTickPin = 1'b0;
		capturePin = 1'b0;
		compInput = 1'b0;
		capSelComparator = 1'b0;
		mismatches = 0;
		tests_run = 0;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_word();
		t_top();
		t_sel();
		t_count();
		t_updown();
		t_cap();
		close_out();
	end
endmodule
